/* File: otpp_pkg.sv */
// Constants, timing counts and enumerations for the fuse-memory programmer.
package otpp_pkg;
    // Clock and word geometry.
    localparam int CLK_PERIOD_NS = 4;
    localparam int WORD_BITS = 70;
    localparam int IDX_W = 7;
    localparam int TMR_W = 12;
    localparam logic [IDX_W-1:0] LAST_IDX = 7'h45;
    localparam logic [IDX_W-1:0] WORD_BITS_IDX = 7'h46;

    // Printed times and frequencies, in their own units.
    localparam int TW_MAX_FREQ_KHZ = 50;
    localparam int BURN_MAX_FREQ_KHZ = 100;
    localparam int READ_MAX_FREQ_KHZ = 100;
    localparam int BURN_PULSE_NS = 1000;
    localparam int BURN_PULSE_TOL_NS = 200;
    localparam int BURN_PRE_NS = 1000;
    localparam int BURN_POST_NS = 1000;
    localparam int SETUP_NS = 100;
    localparam int READ_GAP_NS = 100;

    // A least time rounds up to whole clock cycles.
    function automatic int cyc_ceil(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    // Half periods of the serial clock and other pin timings in cycles; a maximum frequency is a least half period.
    localparam int TW_HALF_CYC = cyc_ceil(1000000 / TW_MAX_FREQ_KHZ / 2);
    localparam int BURN_HALF_CYC = cyc_ceil(1000000 / BURN_MAX_FREQ_KHZ / 2);
    localparam int READ_HALF_CYC = cyc_ceil(1000000 / READ_MAX_FREQ_KHZ / 2);
    localparam int BURN_PULSE_CYC = BURN_PULSE_NS / CLK_PERIOD_NS;
    localparam int BURN_PULSE_TOL_CYC = BURN_PULSE_TOL_NS / CLK_PERIOD_NS;
    localparam int BURN_PRE_CYC = cyc_ceil(BURN_PRE_NS);
    localparam int BURN_POST_CYC = cyc_ceil(BURN_POST_NS);
    localparam int SETUP_CYC = cyc_ceil(SETUP_NS);
    localparam int READ_GAP_CYC = cyc_ceil(READ_GAP_NS) + 1;

    // Cut a cycle count to the timer width.
    function automatic logic [TMR_W-1:0] tcnt(input int c);
        return c[TMR_W-1:0];
    endfunction

    // Procedures the user may request.
    typedef enum logic [1:0] {
        OP_TESTWRITE = 2'h0,
        OP_BURN = 2'h1,
        OP_READ = 2'h2
    } otpp_op_e;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SEL_FALL = 4'h1,
        ST_SEL_CLK = 4'h2,
        ST_SEL_RISE = 4'h3,
        ST_TW_LO = 4'h4,
        ST_TW_HI = 4'h5,
        ST_BU_HI = 4'h6,
        ST_BU_PULSE = 4'h7,
        ST_BU_LO = 4'h8,
        ST_RD_LO = 4'h9,
        ST_RD_HI = 4'hA,
        ST_EX_FALL = 4'hB,
        ST_EX_RISE = 4'hC,
        ST_FINISH = 4'hD
    } otpp_state_e;
endpackage

/* File: otpp_sync.sv */
// Two-flop synchroniser for a level arriving from outside the clock domain.
module otpp_sync (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Asynchronous level and its synchronised copy.
    input wire logic d,
    output logic q
);
    import otpp_pkg::*;

    logic meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 1'h0;
            q <= 1'h0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: otpp_timer.sv */
// Loadable down-counter that paces every pin phase of the sequencer.
module otpp_timer (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Load request with a cycle count of at least one.
    input wire logic load,
    input wire logic [otpp_pkg::TMR_W-1:0] load_val,
    // High once the loaded number of cycles has passed.
    output logic expired
);
    import otpp_pkg::*;

    logic [TMR_W-1:0] cnt;

    // Expiry does not look at load, so the caller may reload on expiry without a loop.
    assign expired = (cnt == '0);

    // Count down to zero and rest there.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= load_val - 1'h1;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'h1;
        end
    end
endmodule

/* File: otpp_programmer.sv */
// Calibration programmer that drives the fuse memory port: trial load, burn and read.
module otpp_programmer (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Command from the user side.
    input wire logic start,
    input wire otpp_pkg::otpp_op_e op,
    input wire logic [otpp_pkg::WORD_BITS-1:0] word_in,
    // Status and read result.
    output logic busy,
    output logic done,
    output logic [otpp_pkg::WORD_BITS-1:0] rd_word,
    // Device pins.
    output logic mode_strobe_pin,
    output logic serial_clock_pin,
    output logic program_data_pin,
    input wire logic cal_pin
);
    import otpp_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    otpp_state_e state, next_state;
    otpp_op_e op_q, next_op;
    logic [WORD_BITS-1:0] word_q, next_word, next_rd;
    logic [IDX_W-1:0] idx, next_idx;
    logic strobe, next_strobe, sclk, next_sclk, data, next_data, next_done;
    logic tmr_load, tmr_exp, cal_s;
    logic [TMR_W-1:0] tmr_val;

    // The read output is an asynchronous pin and is synchronised first.
    otpp_sync u_cal_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .d(cal_pin),
        .q(cal_s)
    );

    // One timer paces all phases; one expiry can change two pins, as clock and strobe in ST_BU_HI.
    otpp_timer u_timer (
        .mclk(mclk),
        .arst_n(arst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_exp)
    );

    // Decoding used by the sequencer.
    wire logic start_ok = start && (op != 2'h3);
    wire logic idx_last = (idx == '0);
    wire logic [IDX_W-1:0] idx_dec = idx - 1'h1;
    wire logic cur_bit = word_q[idx];
    wire logic next_tw_bit = ~word_q[idx_dec];

    // Outputs come from registers; busy is a handshake level.
    assign busy = (state != ST_IDLE);
    assign mode_strobe_pin = strobe;
    assign serial_clock_pin = sclk;
    assign program_data_pin = data;

    // Sequencer: actions outside ST_IDLE and ST_FINISH happen on timer expiry, and all but ST_EX_RISE reload the timer.
    always_comb begin
        next_state = state;
        next_op = op_q;
        next_word = word_q;
        next_rd = rd_word;
        next_idx = idx;
        next_strobe = strobe;
        next_sclk = sclk;
        next_data = data;
        next_done = 1'h0;
        tmr_load = 1'h0;
        tmr_val = tcnt(SETUP_CYC);
        case (state)
            ST_IDLE: begin
                if (start_ok) begin
                    next_op = op;
                    next_word = {word_in[WORD_BITS-1:1], 1'h1};
                    next_sclk = (op == OP_BURN);
                    next_data = 1'h0;
                    tmr_load = 1'h1;
                    next_state = ST_SEL_FALL;
                end
            end
            ST_SEL_FALL: begin
                if (tmr_exp) begin
                    next_strobe = 1'h0;
                    tmr_load = 1'h1;
                    next_state = ST_SEL_CLK;
                end
            end
            ST_SEL_CLK: begin
                if (tmr_exp) begin
                    next_sclk = (op_q == OP_READ);
                    tmr_val = tcnt(READ_GAP_CYC);
                    tmr_load = 1'h1;
                    next_state = ST_SEL_RISE;
                end
            end
            ST_SEL_RISE: begin
                if (tmr_exp) begin
                    next_strobe = 1'h1;
                    next_idx = LAST_IDX;
                    tmr_load = 1'h1;
                    case (op_q)
                        OP_TESTWRITE: begin
                            next_data = ~word_q[LAST_IDX];
                            tmr_val = tcnt(TW_HALF_CYC);
                            next_state = ST_TW_LO;
                        end
                        OP_BURN: begin
                            tmr_val = tcnt(BURN_HALF_CYC);
                            next_state = ST_BU_HI;
                        end
                        default: begin
                            // The clock stays high across the strobe rise, or the part sees trial load.
                            tmr_val = tcnt(READ_HALF_CYC);
                            next_state = ST_RD_LO;
                        end
                    endcase
                end
            end
            ST_TW_LO: begin
                if (tmr_exp) begin
                    next_sclk = 1'h1;
                    tmr_val = tcnt(TW_HALF_CYC);
                    tmr_load = 1'h1;
                    next_state = ST_TW_HI;
                end
            end
            ST_TW_HI: begin
                if (tmr_exp) begin
                    next_sclk = 1'h0;
                    tmr_val = tcnt(TW_HALF_CYC);
                    tmr_load = 1'h1;
                    if (idx_last) begin
                        next_state = ST_FINISH;
                    end else begin
                        next_idx = idx_dec;
                        next_data = next_tw_bit;
                        next_state = ST_TW_LO;
                    end
                end
            end
            ST_BU_HI: begin
                if (tmr_exp) begin
                    next_sclk = 1'h0;
                    tmr_load = 1'h1;
                    if (cur_bit) begin
                        next_strobe = 1'h0;
                        tmr_val = tcnt(BURN_PULSE_CYC);
                        next_state = ST_BU_PULSE;
                    end else begin
                        tmr_val = tcnt(BURN_HALF_CYC);
                        next_state = ST_BU_LO;
                    end
                end
            end
            ST_BU_PULSE: begin
                if (tmr_exp) begin
                    next_strobe = 1'h1;
                    tmr_val = tcnt(BURN_HALF_CYC);
                    tmr_load = 1'h1;
                    next_state = ST_BU_LO;
                end
            end
            ST_BU_LO: begin
                if (tmr_exp) begin
                    tmr_load = 1'h1;
                    if (idx_last) begin
                        // A burn leaves inverted data inside, so a read is chained on.
                        next_op = OP_READ;
                        next_state = ST_SEL_FALL;
                    end else begin
                        next_sclk = 1'h1;
                        next_idx = idx_dec;
                        tmr_val = tcnt(BURN_HALF_CYC);
                        next_state = ST_BU_HI;
                    end
                end
            end
            ST_RD_LO: begin
                if (tmr_exp) begin
                    tmr_val = tcnt(READ_HALF_CYC);
                    tmr_load = 1'h1;
                    if (sclk) begin
                        // Read select leaves the clock high; it drops one phase later.
                        next_sclk = 1'h0;
                    end else begin
                        next_sclk = 1'h1;
                        next_state = ST_RD_HI;
                    end
                end
            end
            ST_RD_HI: begin
                if (tmr_exp) begin
                    // Sampling at the end of the high phase leaves the pin ample settle time.
                    next_rd[idx] = ~cal_s;
                    next_sclk = 1'h0;
                    tmr_val = tcnt(READ_HALF_CYC);
                    tmr_load = 1'h1;
                    if (idx_last) begin
                        next_state = ST_EX_FALL;
                    end else begin
                        next_idx = idx_dec;
                        next_state = ST_RD_LO;
                    end
                end
            end
            ST_EX_FALL: begin
                if (tmr_exp) begin
                    next_strobe = 1'h0;
                    tmr_load = 1'h1;
                    next_state = ST_EX_RISE;
                end
            end
            ST_EX_RISE: begin
                if (tmr_exp) begin
                    next_strobe = 1'h1;
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                next_done = 1'h1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer and pin registers; strobe idles high, clock and data low.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            op_q <= OP_TESTWRITE;
            word_q <= '0;
            rd_word <= '0;
            idx <= '0;
            strobe <= 1'h1;
            sclk <= 1'h0;
            data <= 1'h0;
            done <= 1'h0;
        end else begin
            state <= next_state;
            op_q <= next_op;
            word_q <= next_word;
            rd_word <= next_rd;
            idx <= next_idx;
            strobe <= next_strobe;
            sclk <= next_sclk;
            data <= next_data;
            done <= next_done;
        end
    end

    // Checking helpers: run lengths and edge ages of the driven pins.
    logic sclk_d;
    logic [TMR_W-1:0] strobe_lo_run, clk_hi_run, clk_lo_run, clk_rise_age, strobe_rise_age;
    logic [IDX_W-1:0] edge_cnt;

    function automatic logic [TMR_W-1:0] sat_inc(input logic [TMR_W-1:0] v);
        return (v == '1) ? v : v + 1'h1;
    endfunction

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d <= 1'h0;
            strobe_lo_run <= '0;
            clk_hi_run <= '0;
            clk_lo_run <= '0;
            clk_rise_age <= '1;
            strobe_rise_age <= '1;
            edge_cnt <= '0;
        end else begin
            sclk_d <= sclk;
            strobe_lo_run <= strobe ? '0 : sat_inc(strobe_lo_run);
            clk_hi_run <= sclk ? sat_inc(clk_hi_run) : '0;
            clk_lo_run <= sclk ? '0 : sat_inc(clk_lo_run);
            clk_rise_age <= (sclk && !sclk_d) ? 12'h001 : sat_inc(clk_rise_age);
            strobe_rise_age <= (strobe && strobe_lo_run != '0) ?
                12'h001 : sat_inc(strobe_rise_age);
            edge_cnt <= (state == ST_IDLE) ? '0 :
                ((sclk && !sclk_d) ? edge_cnt + 1'h1 : edge_cnt);
        end
    end

    // Burn pulse lasts its nominal width exactly, inside the tolerance band.
    a_burn_width: assert property (
        $rose(strobe) && $past(state) == ST_BU_PULSE |->
            strobe_lo_run == tcnt(BURN_PULSE_CYC) &&
            strobe_lo_run <= tcnt(BURN_PULSE_CYC + BURN_PULSE_TOL_CYC))
        else $error("burn pulse width wrong");

    a_burn_pre: assert property (
        $fell(strobe) && state == ST_BU_PULSE |-> clk_rise_age >= tcnt(BURN_PRE_CYC))
        else $error("burn pulse too soon after clock edge");

    a_burn_post: assert property (
        $rose(sclk) && state == ST_BU_HI |-> strobe_rise_age >= tcnt(BURN_POST_CYC))
        else $error("clock edge too soon after burn pulse");

    a_burn_ones: assert property (
        $fell(strobe) && state == ST_BU_PULSE |-> word_q[idx] == 1'h1)
        else $error("burn pulse on a zero bit");

    a_tw_count: assert property (
        state == ST_FINISH && op_q == OP_TESTWRITE |-> edge_cnt == WORD_BITS_IDX)
        else $error("trial load clock count wrong");

    a_tw_data: assert property (
        $rose(sclk) && state == ST_TW_HI |-> data == ~word_q[idx] && $stable(data))
        else $error("trial load data not inverted or not stable");

    a_tw_freq: assert property (
        $fell(sclk) && op_q == OP_TESTWRITE && busy |-> clk_hi_run >= tcnt(TW_HALF_CYC))
        else $error("trial load clock too fast");

    a_burn_freq: assert property (
        $rose(sclk) && state == ST_BU_HI |-> clk_lo_run >= tcnt(BURN_HALF_CYC))
        else $error("burn clock too fast");

    a_mode_select: assert property (
        $rose(strobe) && $past(state) == ST_SEL_RISE |-> sclk == (op_q == OP_READ))
        else $error("clock level wrong at mode start");

    a_read_invert: assert property (
        state == ST_RD_HI && tmr_exp |=> rd_word[$past(idx)] == !$past(cal_s))
        else $error("read bit not inverted back");

    a_bit_zero: assert property (
        busy |-> word_q[0] == 1'h1)
        else $error("word bit zero not one");

    a_burn_reads: assert property (
        state == ST_BU_LO && tmr_exp && idx_last |=> state == ST_SEL_FALL && op_q == OP_READ)
        else $error("burn not followed by read");

    c_tw_done: cover property (state == ST_FINISH && op_q == OP_TESTWRITE);
    c_burn_pulse: cover property ($fell(strobe) && state == ST_BU_PULSE);
    c_read_done: cover property (state == ST_FINISH && op_q == OP_READ);
    c_burn_chain: cover property (state == ST_BU_LO ##1 state == ST_SEL_FALL);
endmodule

/* File: otpp_fuse_model.sv */
// Behavioural model of the metering chip's fuse memory port, seen from its pins.
module otpp_fuse_model (
    // Pins driven by the programmer.
    input wire logic mode_strobe_pin,
    input wire logic serial_clock_pin,
    input wire logic program_data_pin,
    // Calibration pulse output, which shows fuse bits while reading.
    output logic cal_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef enum logic [2:0] {DV_IDLE, DV_SEL, DV_TW, DV_BURN, DV_READ} otpp_dev_e;
    otpp_dev_e mode;
    logic [69:0] fuse;
    logic [69:0] shreg;
    logic [69:0] cfg_word;
    logic reg_inverted;
    logic showing;
    logic cal_bit;
    logic pulse;
    logic fall_clk;
    int idx;
    int tw_bits;
    int rd_bits;
    int viol;
    time t_clk;
    time t_fall;
    time t_pulse_end;
    time t_data;

    // The volatile register is kept apart from the fuses, so power loss would only clear it.
    assign cfg_word = ~shreg;
    // Outside a read the pin carries unrelated pulses, never the last fuse bit.
    assign cal_pin = showing ? cal_bit : pulse;

    // Start from a fresh, unburned part.
    initial begin
        mode = DV_IDLE;
        fuse = '0;
        shreg = '0;
        {reg_inverted, showing, cal_bit, pulse, fall_clk} = 5'h00;
        {idx, tw_bits, rd_bits, viol} = {32'd0, 32'd0, 32'd0, 32'd0};
        {t_clk, t_fall, t_pulse_end, t_data} = {64'd0, 64'd0, 64'd0, 64'd0};
    end

    // Free-running stand-in for the normal calibration pulses.
    always #37 pulse = ~pulse;

    // Remember when the data pin last moved, for the setup check.
    always @(program_data_pin) t_data = $time;

    // Entering read reloads the true fuse contents.
    task automatic enter_read;
        mode = DV_READ;
        idx = 70;
        rd_bits = 0;
        reg_inverted = 1'b0;
    endtask

    // A falling strobe selects a mode when idle.
    always @(negedge mode_strobe_pin) begin
        fall_clk = serial_clock_pin;
        t_fall = $time;
        if (mode == DV_IDLE) begin
            mode = DV_SEL;
        end
    end

    // A rising strobe starts a mode, ends a burn pulse or leaves read.
    always @(posedge mode_strobe_pin) begin
        case (mode)
            DV_IDLE: begin
                // The last burn step leaves the part idle, so a rise with the clock high reads.
                if (serial_clock_pin) enter_read();
            end
            DV_SEL: begin
                if (serial_clock_pin) begin
                    enter_read();
                end else if (fall_clk) begin
                    mode = DV_BURN;
                    idx = 69;
                    reg_inverted = 1'b1;
                end else begin
                    mode = DV_TW;
                    tw_bits = 0;
                end
            end
            DV_BURN: begin
                if (serial_clock_pin && !fall_clk) begin
                    enter_read();
                end else begin
                    if ($time - t_fall < 800 || $time - t_fall > 1200) viol++;
                    if (t_fall - t_clk < 1000) viol++;
                    fuse[idx] = 1'b1;
                    t_pulse_end = $time;
                end
            end
            DV_READ: begin
                if ($time - t_clk <= 100) viol++;
                mode = DV_IDLE;
                showing = 1'b0;
            end
            default: begin
            end
        endcase
    end

    // Rising serial clock shifts data in, steps the burn cell or selects a read cell.
    always @(posedge serial_clock_pin) begin
        case (mode)
            DV_TW: begin
                if (tw_bits > 0 && $time - t_clk < 20000) viol++;
                if ($time - t_data < 100) viol++;
                shreg = {shreg[68:0], program_data_pin};
                tw_bits++;
                if (tw_bits == 70) mode = DV_IDLE;
            end
            DV_BURN: begin
                if (idx < 69 && $time - t_clk < 10000) viol++;
                if (t_pulse_end > t_clk && $time - t_pulse_end < 1000) viol++;
                if (idx == 0) mode = DV_IDLE;
                else idx--;
            end
            DV_READ: begin
                if (rd_bits > 0 && $time - t_clk < 10000) viol++;
                if (idx > 0) idx--;
                rd_bits++;
                showing = 1'b1;
                cal_bit <= #50 ~fuse[idx];
            end
            default: begin
            end
        endcase
        t_clk = $time;
    end
endmodule

/* File: otpp_programmer_tb_top.sv */
// Self-checking bench: programmer against the fuse memory model.
module otpp_programmer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import otpp_pkg::*;
    logic mclk;
    logic arst_n;
    logic start;
    otpp_op_e op;
    logic [WORD_BITS-1:0] word_in;
    logic busy;
    logic done;
    logic [WORD_BITS-1:0] rd_word;
    logic mode_strobe_pin;
    logic serial_clock_pin;
    logic program_data_pin;
    logic cal_pin;
    int err_total;
    int comparisons;
    logic [15:0] lfsr;
    logic [WORD_BITS-1:0] w;
    logic [WORD_BITS-1:0] e;

    otpp_programmer DUT (
        .mclk(mclk), .arst_n(arst_n), .start(start), .op(op), .word_in(word_in),
        .busy(busy), .done(done), .rd_word(rd_word), .mode_strobe_pin(mode_strobe_pin),
        .serial_clock_pin(serial_clock_pin), .program_data_pin(program_data_pin),
        .cal_pin(cal_pin)
    );
    otpp_fuse_model dev (
        .mode_strobe_pin(mode_strobe_pin), .serial_clock_pin(serial_clock_pin),
        .program_data_pin(program_data_pin), .cal_pin(cal_pin)
    );

    // Clock at 250 MHz.
    always #2 mclk = ~mclk;

    // Sixteen-bit feedback shift register; five steps fill one word.
    function automatic logic [WORD_BITS-1:0] rand_word();
        logic [79:0] acc;
        acc = '0;
        for (int i = 0; i < 5; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            acc = {acc[63:0], lfsr};
        end
        return acc[WORD_BITS-1:0];
    endfunction

    // The word that should end up stored: bit zero is always one.
    function automatic logic [WORD_BITS-1:0] exp_word(input logic [WORD_BITS-1:0] x);
        return {x[WORD_BITS-1:1], 1'b1};
    endfunction

    // Compare and count.
    task automatic check(input logic [WORD_BITS-1:0] seen, input logic [WORD_BITS-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run.
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One procedure; a poke requests a burn while busy, which must be ignored.
    task automatic run_op(input otpp_op_e o, input logic [WORD_BITS-1:0] x, input logic poke);
        int n;
        @(posedge mclk);
        start <= 1'b1;
        op <= o;
        word_in <= x;
        @(posedge mclk);
        start <= 1'b0;
        #1 check(busy, 1'b1);
        if (poke) begin
            @(posedge mclk);
            start <= 1'b1;
            op <= OP_BURN;
            @(posedge mclk);
            start <= 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && n < 400000) begin
            @(posedge mclk);
            #1 n++;
        end
        check(done, 1'b1);
        @(posedge mclk);
        #1 check({busy, done}, 2'h0);
    endtask

    // Hang guard, well beyond the expected length of the run.
    initial begin
        repeat (1200000) @(posedge mclk);
        err_total++;
        results();
    end

    // Main sequence.
    initial begin
        {mclk, arst_n, start} = 3'h0;
        op = OP_TESTWRITE;
        word_in = '0;
        err_total = 0;
        comparisons = 0;
        lfsr = 16'h0024;
        repeat (4) @(posedge mclk);
        #1 check({mode_strobe_pin, serial_clock_pin, program_data_pin, busy, done}, 5'h10);
        check(rd_word, '0);
        @(posedge mclk);
        arst_n <= 1'b1;
        // An undefined code must be ignored.
        @(posedge mclk);
        start <= 1'b1;
        op <= otpp_op_e'(2'h3);
        @(posedge mclk);
        start <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 check(busy, 1'b0);
        // Trial load with bit zero clear: it must still arrive as one, and nothing is burned.
        w = rand_word() & ~70'h1;
        run_op(OP_TESTWRITE, w, 1'b1);
        check(dev.cfg_word, exp_word(w));
        check(70'(dev.tw_bits), 70'h46);
        check(dev.fuse, '0);
        // Burn, with the chained read giving back the true word.
        w = rand_word();
        e = exp_word(w);
        run_op(OP_BURN, w, 1'b0);
        check(dev.fuse, e);
        check(rd_word, e);
        check(dev.reg_inverted, 1'b0);
        // Back-to-back plain read of the same fuses.
        run_op(OP_READ, rand_word(), 1'b0);
        check(rd_word, e);
        check(70'(dev.rd_bits), 70'h46);
        check(dev.showing, 1'b0);
        check(70'(dev.viol), '0);
        results();
    end
endmodule
